// ---- src/smps_pkg.sv ----
// Constants, carriers and keyword tree of the message parser and status block.
// Assumes a single clock; software reaches the registers over APB.
package smps_pkg;

   // Register byte offsets
   localparam logic [7:0] OFF_QUES_EVENT  = 8'h00;
   localparam logic [7:0] OFF_QUES_COND   = 8'h04;
   localparam logic [7:0] OFF_QUES_ENABLE = 8'h08;
   localparam logic [7:0] OFF_OPER_EVENT  = 8'h0c;
   localparam logic [7:0] OFF_OPER_COND   = 8'h10;
   localparam logic [7:0] OFF_OPER_ENABLE = 8'h14;
   localparam logic [7:0] OFF_STD_EVENT   = 8'h18;
   localparam logic [7:0] OFF_STD_ENABLE  = 8'h1c;
   localparam logic [7:0] OFF_STB         = 8'h20;
   localparam logic [7:0] OFF_SRQ_ENABLE  = 8'h24;
   localparam logic [7:0] OFF_ERR_COUNT   = 8'h28;
   localparam logic [7:0] OFF_ERR_POP     = 8'h2c;

   // Reset values
   localparam logic [15:0] RST_EN16 = 16'h0000;
   localparam logic [7:0]  RST_EN8  = 8'h00;

   // Status byte bit positions
   localparam int STB_QUES = 3;
   localparam int STB_MAV  = 4;
   localparam int STB_ESB  = 5;
   localparam int STB_RQS  = 6;
   localparam int STB_OPER = 7;

   // Characters
   localparam logic [7:0] CH_LF    = 8'h0a;
   localparam logic [7:0] CH_SEMI  = 8'h3b;
   localparam logic [7:0] CH_COLON = 8'h3a;
   localparam logic [7:0] CH_QMARK = 8'h3f;
   localparam logic [7:0] CH_SPACE = 8'h20;
   localparam logic [7:0] CH_STAR  = 8'h2a;
   localparam logic [7:0] CH_CASE  = 8'h20;

   // Error codes posted to the error queue
   localparam logic [7:0] ERR_SYNTAX    = 8'h01;
   localparam logic [7:0] ERR_UNDEF_HDR = 8'h02;

   localparam int          KW_CHARS  = 12;
   localparam logic [3:0]  ROOT_ID   = 4'h0;
   localparam logic [3:0]  OPT_ID    = 4'h1;
   localparam logic [3:0]  COMMON_ID = 4'hf;
   localparam int          KW_N      = 14;

   typedef struct packed {
      logic [3:0] id;
      logic       common;
      logic       query;
      logic       has_param;
   } smps_cmd_t;

   // Name is right aligned, first letter highest
   typedef struct packed {
      logic [KW_CHARS*8-1:0] name;
      logic [3:0]            len;
      logic [3:0]            parent;
   } smps_kw_t;

   // Entry index is the node id; entry 1 is the optional root keyword
   localparam smps_kw_t KW_TABLE [1:KW_N] = '{
      '{96'("SOURCE"),       4'd6,  4'd0},
      '{96'("VOLTAGE"),      4'd7,  4'd1},
      '{96'("CURRENT"),      4'd7,  4'd1},
      '{96'("LEVEL"),        4'd5,  4'd2},
      '{96'("LEVEL"),        4'd5,  4'd3},
      '{96'("MEASURE"),      4'd7,  4'd0},
      '{96'("VOLTAGE"),      4'd7,  4'd6},
      '{96'("CURRENT"),      4'd7,  4'd6},
      '{96'("STATUS"),       4'd6,  4'd0},
      '{96'("OPERATION"),    4'd9,  4'd9},
      '{96'("QUESTIONABLE"), 4'd12, 4'd9},
      '{96'("ENABLE"),       4'd6,  4'd10},
      '{96'("ENABLE"),       4'd6,  4'd11},
      '{96'("EVENT"),        4'd5,  4'd10}
   };

endpackage

// ---- src/smps_top.sv ----
// Text message parser with status byte, event registers and APB slave.
// Characters and condition bits come from logic on clk_i; no resynchroniser.
//
// Chosen here: the address map and register access over APB.
`timescale 1ns/10ps

//Function
//- A question mark right after the last keyword makes a query.
//- Parameter follows the last keyword after one space.
//- Semicolon ends one message unit inside a message.
//- Leading colon of a unit returns the tree position to root.
//- Line feed, 0A hex, is the only message terminator.
//- Terminator or root specifier returns the position to root.
//- Optional root keyword may be omitted; its children work at root.
//- Keyword separator colon descends below the keyword just decoded.
//- After a plain semicolon the next keyword is a sibling.
//- Unit starting with asterisk is a common command.
//- Only exact short form or full long form is accepted.
//- Keyword matching ignores letter case.
//- Clean decode leaves status byte bit 3 at zero.
//- Status byte bit 4 shows reply data waiting.
//- Questionable, operation 16 bit; standard event, service 8 bit.
//- Condition bit rising edge sets its event bit.
//- Reading an event register clears it.
//- Enabled questionable event sets status byte bit 3.
//- Enabled status bits except 6 OR into bit 6 and drive SRQ.
//- Non-empty error queue keeps status byte bit 3 set.
//- Short form is four letters, three if the fourth is a vowel.
//- Adjacent keywords are joined by a colon.
module smps_top
   import smps_pkg::*;
#(
   parameter int ERRQ_DEPTH = 8
) (
   input  wire logic        clk_i,
   input  wire logic        reset_i,
   input  wire logic        char_valid_i,
   input  wire logic [7:0]  char_i,
   input  wire logic        reply_pending_i,
   input  wire logic [15:0] ques_cond_i,
   input  wire logic [15:0] oper_cond_i,
   input  wire logic [7:0]  std_event_i,
   input  wire logic        psel_i,
   input  wire logic        penable_i,
   input  wire logic        pwrite_i,
   input  wire logic [7:0]  paddr_i,
   input  wire logic [31:0] pwdata_i,
   output logic      [31:0] prdata_o,
   output logic             pready_o,
   output logic             pslverr_o,
   output logic             cmd_valid_o,
   output smps_cmd_t        cmd_o,
   output logic             param_valid_o,
   output logic      [7:0]  param_char_o,
   output logic      [7:0]  status_byte_o,
   output logic             srq_o
);

   typedef enum logic [2:0] {P_START, P_KEY, P_QUERY, P_PARAM, P_SKIP}
      smps_pst_t;

   localparam int EQW = $clog2(ERRQ_DEPTH);

   function automatic logic is_vowel(logic [7:0] c);
      is_vowel = (c == "A") || (c == "E") || (c == "I") ||
                 (c == "O") || (c == "U");
   endfunction

   function automatic logic kw_match(smps_kw_t e, logic [95:0] b,
                                     logic [3:0] n);
      int         idx;
      logic [3:0] s;
      idx = (int'(e.len) - 4) * 8;
      if (idx < 0)
         idx = 0;
      if (e.len <= 4'd4)
         s = e.len;
      else if (is_vowel(e.name[idx +: 8]))
         s = 4'd3;
      else
         s = 4'd4;
      kw_match = (n != 4'd0) &&
                 ((n == e.len && b == e.name) ||
                  (n == s && b == (e.name >> ((int'(e.len) - int'(s)) * 8))));
   endfunction

   smps_pst_t   pst_q;
   logic [95:0] kbuf_q;
   logic [3:0]  klen_q, level_q, last_id_q;
   logic        common_q, query_q, param_q, err_push_q;
   logic [7:0]  err_code_q;
   logic [7:0]  up_c;
   logic        letter_c, kw_hit, fin_ok, fin_err;
   logic [3:0]  kw_id, fin_id;
   logic        cmd_valid_q, param_valid_q;
   smps_cmd_t   cmd_q;
   logic [7:0]  param_char_q;

   always_comb begin
      up_c = (char_i >= "a" && char_i <= "z") ? char_i - CH_CASE : char_i;
      letter_c = up_c >= "A" && up_c <= "Z";
   end

   always_comb begin
      kw_hit = 1'b0;
      kw_id = ROOT_ID;
      for (int i = 1; i <= KW_N; i++) begin
         if (!kw_hit && kw_match(KW_TABLE[i], kbuf_q, klen_q) &&
             (KW_TABLE[i].parent == level_q ||
              (KW_TABLE[i].parent == OPT_ID && level_q == ROOT_ID))) begin
            kw_hit = 1'b1;
            kw_id = 4'(i);
         end
      end
   end

   always_comb begin
      fin_id = (pst_q == P_KEY) ? (common_q ? COMMON_ID : kw_id) : last_id_q;
      fin_ok = (pst_q == P_QUERY) || (pst_q == P_PARAM) ||
               (pst_q == P_KEY && (common_q ? klen_q != 4'd0 : kw_hit));
      fin_err = (pst_q == P_KEY) && !fin_ok;
   end

   // Parser
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         pst_q <= P_START;
         kbuf_q <= '0;
         klen_q <= 4'h0;
         level_q <= ROOT_ID;
         last_id_q <= ROOT_ID;
         common_q <= 1'b0;
         query_q <= 1'b0;
         param_q <= 1'b0;
         err_push_q <= 1'b0;
         err_code_q <= 8'h00;
         cmd_valid_q <= 1'b0;
         cmd_q <= '0;
         param_valid_q <= 1'b0;
         param_char_q <= 8'h00;
      end else begin
         cmd_valid_q <= 1'b0;
         param_valid_q <= 1'b0;
         err_push_q <= 1'b0;
         if (char_valid_i) begin
            if (char_i == CH_LF || char_i == CH_SEMI) begin
               if (fin_ok) begin
                  cmd_valid_q <= 1'b1;
                  cmd_q <= '{fin_id, common_q, query_q, param_q};
               end
               if (fin_err) begin
                  err_push_q <= 1'b1;
                  err_code_q <= ERR_UNDEF_HDR;
               end
               pst_q <= P_START;
               kbuf_q <= '0;
               klen_q <= 4'h0;
               common_q <= 1'b0;
               query_q <= 1'b0;
               param_q <= 1'b0;
               if (char_i == CH_LF)
                  level_q <= ROOT_ID;
            end else begin
               case (pst_q)
                  P_START: begin
                     if (char_i == CH_COLON) begin
                        level_q <= ROOT_ID;
                        pst_q <= P_KEY;
                     end else if (char_i == CH_STAR) begin
                        common_q <= 1'b1;
                        pst_q <= P_KEY;
                     end else if (letter_c) begin
                        kbuf_q <= {88'h0, up_c};
                        klen_q <= 4'h1;
                        pst_q <= P_KEY;
                     end else if (char_i != CH_SPACE) begin
                        err_push_q <= 1'b1;
                        err_code_q <= ERR_SYNTAX;
                        pst_q <= P_SKIP;
                     end
                  end
                  P_KEY: begin
                     if (letter_c && klen_q < 4'(KW_CHARS)) begin
                        kbuf_q <= {kbuf_q[87:0], up_c};
                        klen_q <= klen_q + 4'h1;
                     end else if (char_i == CH_COLON && !common_q && kw_hit) begin
                        level_q <= kw_id;
                        kbuf_q <= '0;
                        klen_q <= 4'h0;
                     end else if (char_i == CH_QMARK && fin_ok) begin
                        query_q <= 1'b1;
                        last_id_q <= fin_id;
                        pst_q <= P_QUERY;
                     end else if (char_i == CH_SPACE && fin_ok) begin
                        last_id_q <= fin_id;
                        pst_q <= P_PARAM;
                     end else begin
                        err_push_q <= 1'b1;
                        err_code_q <= kw_hit ? ERR_SYNTAX : ERR_UNDEF_HDR;
                        pst_q <= P_SKIP;
                     end
                  end
                  P_QUERY: begin
                     if (char_i == CH_SPACE) begin
                        pst_q <= P_PARAM;
                     end else begin
                        err_push_q <= 1'b1;
                        err_code_q <= ERR_SYNTAX;
                        pst_q <= P_SKIP;
                     end
                  end
                  P_PARAM: begin
                     param_valid_q <= 1'b1;
                     param_char_q <= char_i;
                     if (char_i != CH_SPACE)
                        param_q <= 1'b1;
                  end
                  default: begin
                  end
               endcase
            end
         end
      end
   end

   // APB slave: pready one cycle into the access phase
   logic        pready_q, pslverr_q, rd_done;
   logic [31:0] prdata_q;
   logic [32:0] rd_c;

   logic [15:0] ques_prev_q, oper_prev_q, ques_ev_q, oper_ev_q;
   logic [15:0] ques_en_q, oper_en_q, ques_rise, oper_rise;
   logic [15:0] ques_clr, oper_clr;
   logic [7:0]  std_ev_q, std_en_q, sre_q, std_clr, stb_c, stb_q;
   logic        srq_q;
   logic [7:0]  eq_mem [ERRQ_DEPTH];
   logic [EQW-1:0] eq_wr_q, eq_rd_q;
   logic [EQW:0]   eq_cnt_q;

   always_comb begin
      rd_done = psel_i && penable_i && pready_q && !pwrite_i;
      ques_rise = ques_cond_i & ~ques_prev_q;
      oper_rise = oper_cond_i & ~oper_prev_q;
      ques_clr = (rd_done && paddr_i == OFF_QUES_EVENT) ? prdata_q[15:0] : '0;
      oper_clr = (rd_done && paddr_i == OFF_OPER_EVENT) ? prdata_q[15:0] : '0;
      std_clr = (rd_done && paddr_i == OFF_STD_EVENT) ? prdata_q[7:0] : '0;
   end

   function automatic logic [32:0] rd_mux(logic [7:0] a);
      if (a == OFF_QUES_EVENT)       rd_mux = {17'h0, ques_ev_q};
      else if (a == OFF_QUES_COND)   rd_mux = {17'h0, ques_cond_i};
      else if (a == OFF_QUES_ENABLE) rd_mux = {17'h0, ques_en_q};
      else if (a == OFF_OPER_EVENT)  rd_mux = {17'h0, oper_ev_q};
      else if (a == OFF_OPER_COND)   rd_mux = {17'h0, oper_cond_i};
      else if (a == OFF_OPER_ENABLE) rd_mux = {17'h0, oper_en_q};
      else if (a == OFF_STD_EVENT)   rd_mux = {25'h0, std_ev_q};
      else if (a == OFF_STD_ENABLE)  rd_mux = {25'h0, std_en_q};
      else if (a == OFF_STB)         rd_mux = {25'h0, stb_q};
      else if (a == OFF_SRQ_ENABLE)  rd_mux = {25'h0, sre_q};
      else if (a == OFF_ERR_COUNT)   rd_mux = {1'b0, 32'(eq_cnt_q)};
      else if (a == OFF_ERR_POP)
         rd_mux = {25'h0, (eq_cnt_q != '0) ? eq_mem[eq_rd_q] : 8'h00};
      else                           rd_mux = {1'b1, 32'h0};
   endfunction

   // Process, not assign, so state read inside the function is tracked
   always_comb begin
      rd_c = rd_mux(paddr_i);
   end

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q <= 32'h0;
      end else begin
         pready_q <= psel_i && penable_i && !pready_q;
         if (psel_i && penable_i && !pready_q) begin
            {pslverr_q, prdata_q} <= pwrite_i ? {rd_c[32], 32'h0} : rd_c;
         end else begin
            pslverr_q <= 1'b0;
         end
      end
   end

   // Enables written at the completing edge
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         ques_en_q <= RST_EN16;
         oper_en_q <= RST_EN16;
         std_en_q <= RST_EN8;
         sre_q <= RST_EN8;
      end else if (psel_i && penable_i && pready_q && pwrite_i) begin
         if (paddr_i == OFF_QUES_ENABLE)      ques_en_q <= pwdata_i[15:0];
         else if (paddr_i == OFF_OPER_ENABLE) oper_en_q <= pwdata_i[15:0];
         else if (paddr_i == OFF_STD_ENABLE)  std_en_q <= pwdata_i[7:0];
         else if (paddr_i == OFF_SRQ_ENABLE)  sre_q <= pwdata_i[7:0];
      end
   end

   // Only bits already returned are cleared, so a late event survives
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         ques_prev_q <= '0;
         oper_prev_q <= '0;
         ques_ev_q <= '0;
         oper_ev_q <= '0;
         std_ev_q <= '0;
      end else begin
         ques_prev_q <= ques_cond_i;
         oper_prev_q <= oper_cond_i;
         ques_ev_q <= (ques_ev_q & ~ques_clr) | ques_rise;
         oper_ev_q <= (oper_ev_q & ~oper_clr) | oper_rise;
         std_ev_q <= (std_ev_q & ~std_clr) | std_event_i;
      end
   end

   // Error queue; a push when full is dropped
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         eq_wr_q <= '0;
         eq_rd_q <= '0;
         eq_cnt_q <= '0;
      end else begin
         if (err_push_q && eq_cnt_q != (EQW+1)'(ERRQ_DEPTH)) begin
            eq_mem[eq_wr_q] <= err_code_q;
            eq_wr_q <= EQW'((int'(eq_wr_q) + 1) % ERRQ_DEPTH);
         end
         if (rd_done && paddr_i == OFF_ERR_POP && eq_cnt_q != '0)
            eq_rd_q <= EQW'((int'(eq_rd_q) + 1) % ERRQ_DEPTH);
         eq_cnt_q <= eq_cnt_q +
            (EQW+1)'(err_push_q && eq_cnt_q != (EQW+1)'(ERRQ_DEPTH)) -
            (EQW+1)'(rd_done && paddr_i == OFF_ERR_POP && eq_cnt_q != '0);
      end
   end

   always_comb begin
      stb_c = 8'h00;
      stb_c[STB_QUES] = |(ques_ev_q & ques_en_q) || eq_cnt_q != '0;
      stb_c[STB_MAV] = reply_pending_i;
      stb_c[STB_ESB] = |(std_ev_q & std_en_q);
      stb_c[STB_OPER] = |(oper_ev_q & oper_en_q);
      stb_c[STB_RQS] = |(stb_c & sre_q);
   end

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         stb_q <= 8'h00;
         srq_q <= 1'b0;
      end else begin
         stb_q <= stb_c;
         srq_q <= stb_c[STB_RQS];
      end
   end

   always_comb begin
      prdata_o = prdata_q;
      pready_o = pready_q;
      pslverr_o = pslverr_q;
      cmd_valid_o = cmd_valid_q;
      cmd_o = cmd_q;
      param_valid_o = param_valid_q;
      param_char_o = param_char_q;
      status_byte_o = stb_q;
      srq_o = srq_q;
   end

   default clocking @(posedge clk_i); endclocking
   default disable iff (reset_i);

   sequence s_query_key;
      char_valid_i && char_i == CH_QMARK && pst_q == P_KEY && kw_hit &&
      !common_q;
   endsequence
   sequence s_term;
      char_valid_i && char_i == CH_LF;
   endsequence

   AST_QUERY_EMIT: assert property (s_query_key ##1 s_term |=>
      cmd_valid_o && cmd_o.query && cmd_o.id == $past(last_id_q))
      else $error("query unit not emitted as query");
   AST_LF_ROOT: assert property (s_term |=> level_q == ROOT_ID)
      else $error("terminator did not return to root");
   AST_ROOT_SPEC: assert property (char_valid_i && char_i == CH_COLON &&
      pst_q == P_START |=> level_q == ROOT_ID && pst_q == P_KEY)
      else $error("root specifier ignored");
   AST_DESCEND: assert property (char_valid_i && char_i == CH_COLON &&
      pst_q == P_KEY && kw_hit && !common_q |=> level_q == $past(kw_id))
      else $error("separator did not descend");
   AST_SEMI_LEVEL: assert property (char_valid_i && char_i == CH_SEMI
      |=> level_q == $past(level_q))
      else $error("semicolon changed tree level");
   AST_BAD_UNIT: assert property (char_valid_i && char_i == CH_SEMI &&
      pst_q == P_KEY && !common_q && !kw_hit |=> !cmd_valid_o && err_push_q
      ##1 eq_cnt_q != '0)
      else $error("bad unit not rejected");
   AST_EVENT_SET: assert property (1'b1 |=>
      (ques_ev_q & $past(ques_rise)) == $past(ques_rise))
      else $error("rising condition lost");
   AST_READ_CLEAR: assert property (rd_done && paddr_i == OFF_QUES_EVENT
      |=> (ques_ev_q & $past(prdata_q[15:0]) & ~$past(ques_rise)) == '0)
      else $error("event read did not clear");
   AST_ERRQ_BIT3: assert property (eq_cnt_q != '0 |=>
      status_byte_o[STB_QUES])
      else $error("error queue not shown in bit 3");
   AST_MAV: assert property (reply_pending_i |=> status_byte_o[STB_MAV])
      else $error("reply waiting not shown");
   AST_SRQ: assert property (|(stb_c & sre_q) |=> srq_o &&
      status_byte_o[STB_RQS])
      else $error("service request not raised");

endmodule

// ---- testbench/smps_host_model.sv ----
// Host controller model: sends program messages, one character a cycle.
// Assumes the parser takes a character on every edge with the strobe high.
`timescale 1ns/10ps
module smps_host_model
   import smps_pkg::*;
(
   input  wire logic       clk_i,
   output logic            char_valid_o,
   output logic [7:0]      char_o
);
   initial begin
      char_valid_o = 1'b0;
      char_o       = 8'h00;
   end

   task automatic send(input string s);
      logic [7:0] c;
      for (int i = 0; i <= s.len(); i++) begin
         c = (i == s.len()) ? CH_LF : 8'(s[i]);
         @(posedge clk_i);
         char_valid_o <= 1'b1;
         char_o       <= c;
      end
      @(posedge clk_i);
      char_valid_o <= 1'b0;
      // Stale character inverted so it can never pass as a fresh one
      char_o       <= ~CH_LF;
   endtask
endmodule

// ---- testbench/tb.sv ----
// Bench for the message parser and status block: host model plus APB.
// Assumes one APB wait cycle and a two-cycle status byte latency.
`timescale 1ns/10ps
module tb
   import smps_pkg::*;
;
   logic clk_i, reset_i, reply_i, psel, pen, pwr, cv, pv;
   logic [7:0] ch, pch, sb, pa, lastp, se;
   logic [15:0] qc, oc;
   logic [31:0] pwd, prd, rd;
   logic rdy, err, cvo, srq, e;
   smps_cmd_t cmd, cq[$];
   int n_errors, n_compared;

   smps_host_model host_u (.clk_i(clk_i), .char_valid_o(cv), .char_o(ch));
   smps_top dut_u (.clk_i(clk_i), .reset_i(reset_i), .char_valid_i(cv),
      .char_i(ch), .reply_pending_i(reply_i), .ques_cond_i(qc),
      .oper_cond_i(oc), .std_event_i(se), .psel_i(psel),
      .penable_i(pen), .pwrite_i(pwr), .paddr_i(pa), .pwdata_i(pwd),
      .prdata_o(prd), .pready_o(rdy), .pslverr_o(err), .cmd_valid_o(cvo),
      .cmd_o(cmd), .param_valid_o(pv), .param_char_o(pch),
      .status_byte_o(sb), .srq_o(srq));

   initial begin
      clk_i = 1'b0;
      forever #4 clk_i = ~clk_i;
   end

   always @(posedge clk_i) begin
      if (cvo === 1'b1) cq.push_back(cmd);
      if (pv === 1'b1) lastp = pch;
   end

   task finish_test;
      $display("compared %0d errors %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask

   task check(input string what, input logic [31:0] seen, exp);
      n_compared++;
      if (seen !== exp) begin
         n_errors++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      psel <= 1'b1;
      pen  <= 1'b0;
      pwr  <= w;
      pa   <= a;
      pwd  <= d;
      @(posedge clk_i);
      pen <= 1'b1;
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (rdy !== 1'b1 && n < 20);
      rd = prd;
      e  = err;
      psel <= 1'b0;
      pen  <= 1'b0;
      if (n >= 20) begin
         n_errors++;
         finish_test();
      end
      @(posedge clk_i);
   endtask

   task run(input string s);
      cq.delete();
      host_u.send(s);
      repeat (4) @(posedge clk_i);
   endtask

   function automatic logic [31:0] mk(logic [3:0] id, logic c, q, p);
      return {25'h0, id, c, q, p};
   endfunction

   initial begin
      {reset_i, reply_i, psel, pen, pwr, pa, pwd, qc, oc, se} = '0;
      {n_errors, n_compared} = '0;
      reset_i = 1'b1;
      repeat (6) @(posedge clk_i);
      reset_i <= 1'b0;
      @(posedge clk_i);
      run("vOlT?");
      check("count", cq.size(), 1);
      check("cmd", cq[0], mk(2, 0, 1, 0));
      run("MEAS:VOLT?;CURR?");
      check("count", cq.size(), 2);
      check("cmd", cq[0], mk(7, 0, 1, 0));
      check("cmd", cq[1], mk(8, 0, 1, 0));
      run("MEAS:VOLT;:CURR");
      check("cmd", cq[1], mk(3, 0, 0, 0));
      run("VOLTAGE:LEV 5");
      check("cmd", cq[0], mk(4, 0, 0, 1));
      check("param", lastp, "5");
      run("*rst");
      check("cmd", cq[0], mk(15, 1, 0, 0));
      $display("test parser done");
      check("clean", sb[STB_QUES], 1'b0);
      run("VOLTA;VOLT");
      check("count", cq.size(), 1);
      check("cmd", cq[0], mk(2, 0, 0, 0));
      apb(1'b0, OFF_ERR_COUNT, 0);
      check("errcount", rd, 1);
      check("errbit", sb[STB_QUES], 1'b1);
      apb(1'b0, OFF_ERR_POP, 0);
      check("errcode", rd, ERR_UNDEF_HDR);
      repeat (3) @(posedge clk_i);
      check("errbit", sb[STB_QUES], 1'b0);
      $display("test errors done");
      apb(1'b0, OFF_QUES_ENABLE, 0);
      check("rst", rd, 0);
      apb(1'b1, OFF_QUES_ENABLE, 32'hffffffff);
      apb(1'b0, OFF_QUES_ENABLE, 0);
      check("width", rd, 32'h0000ffff);
      apb(1'b1, OFF_SRQ_ENABLE, 32'h00000008);
      apb(1'b1, OFF_OPER_ENABLE, 32'h00000001);
      apb(1'b1, OFF_STD_ENABLE, 32'h00000001);
      qc <= 16'h0001;
      oc <= 16'h0001;
      se <= 8'h01;
      @(posedge clk_i);
      se <= 8'h00;
      repeat (4) @(posedge clk_i);
      check("sum", sb[STB_QUES], 1'b1);
      check("opersum", sb[STB_OPER], 1'b1);
      check("stdsum", sb[STB_ESB], 1'b1);
      check("srq", {sb[STB_RQS], srq}, 2'b11);
      apb(1'b0, OFF_QUES_EVENT, 0);
      check("event", rd, 1);
      apb(1'b0, OFF_QUES_EVENT, 0);
      check("cleared", rd, 0);
      apb(1'b0, OFF_OPER_EVENT, 0);
      check("oper", rd, 1);
      apb(1'b0, OFF_STD_EVENT, 0);
      check("std", rd, 1);
      repeat (3) @(posedge clk_i);
      check("srq", srq, 1'b0);
      reply_i <= 1'b1;
      repeat (4) @(posedge clk_i);
      check("reply", sb[STB_MAV], 1'b1);
      apb(1'b0, 8'h30, 0);
      check("slverr", e, 1'b1);
      check("unmapped", rd, 0);
      $display("test status done");
      finish_test();
   end
endmodule
